// ### core/strobe_flash_defines.svh
`ifndef STROBE_FLASH_DEFINES_SVH
`define STROBE_FLASH_DEFINES_SVH

// ==========================================================
// Register addresses
`define ADDR_CTRL0          16'h3B00
`define ADDR_DUMMY_HIGH     16'h3B02
`define ADDR_DUMMY_LOW      16'h3B03
`define ADDR_CTRL4          16'h3B04
`define ADDR_CTRL5          16'h3B05

// ==========================================================
// Reset values
`define RST_CTRL0           8'h00
`define RST_DUMMY           8'h00
`define RST_CTRL4           8'h00
`define RST_CTRL5           8'h00
`define RD_UNMAPPED         8'h00

// ==========================================================
// Writable bit masks (reserved bits read as zero)
`define MASK_CTRL0          8'hF7
`define MASK_CTRL4          8'h0F
`define MASK_FULL           8'hFF

// ==========================================================
// Field positions
`define REQ_BIT             7
`define POL_BIT             6
`define XWIDTH_MSB          5
`define XWIDTH_LSB          4
`define MODE_MSB            2
`define MODE_LSB            0
`define START_SEL_BIT       3
`define REPEAT_BIT          2
`define LATENCY_MSB         1
`define LATENCY_LSB         0
`define STEP_MSB            7
`define STEP_LSB            2
`define GAIN_MSB            1
`define GAIN_LSB            0

// ==========================================================
// Mode codes
`define MODE_XENON_CODE     3'h0
`define MODE_LED1_CODE      3'h1
`define MODE_LED2_CODE      3'h2
`define MODE_LED3_CODE      3'h3
`define MODE_LED4_CODE      3'h4

// ==========================================================
// Timing counts
`define XENON_FRAME_BASE    3'h3
`define LED12_FRAME_BASE    3'h2
`define OTHER_FRAME_BASE    3'h1
`define WAIT_LAST           3'h1
`define WIDTH_UNIT_SHIFT    5'h07
`define WIDTH_BITS          17

`endif

// ### core/strobe_flash_pkg.sv
`include "strobe_flash_defines.svh"

package strobe_flash_pkg;

   typedef enum logic [2:0] {
      MODE_XENON = `MODE_XENON_CODE,
      MODE_LED1  = `MODE_LED1_CODE,
      MODE_LED2  = `MODE_LED2_CODE,
      MODE_LED3  = `MODE_LED3_CODE,
      MODE_LED4  = `MODE_LED4_CODE
   } strobe_mode_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_WAIT  = 5'h02,
      ST_ALIGN = 5'h04,
      ST_PULSE = 5'h08,
      ST_GAP   = 5'h10
   } strobe_state_t;

endpackage

// ### core/strobe_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "strobe_flash_defines.svh"

module strobe_regs
   import strobe_flash_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [15:0] regAddr,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  ctrl0,
   output logic      [7:0]  dummyHigh,
   output logic      [7:0]  dummyLow,
   output logic      [7:0]  ctrl4,
   output logic      [7:0]  ctrl5,
   output logic      [7:0]  regRdData
);

   // ==========================================================
   // Register writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl0     <= `RST_CTRL0;
         dummyHigh <= `RST_DUMMY;
         dummyLow  <= `RST_DUMMY;
         ctrl4     <= `RST_CTRL4;
         ctrl5     <= `RST_CTRL5;
      end else if (regWrite) begin
         case (regAddr)
            `ADDR_CTRL0:      ctrl0     <= regWrData & `MASK_CTRL0;
            `ADDR_DUMMY_HIGH: dummyHigh <= regWrData;
            `ADDR_DUMMY_LOW:  dummyLow  <= regWrData;
            `ADDR_CTRL4:      ctrl4     <= regWrData & `MASK_CTRL4;
            `ADDR_CTRL5:      ctrl5     <= regWrData & `MASK_FULL;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Register reads, one cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regRdData <= `RD_UNMAPPED;
      end else if (regRead) begin
         case (regAddr)
            `ADDR_CTRL0:      regRdData <= ctrl0;
            `ADDR_DUMMY_HIGH: regRdData <= dummyHigh;
            `ADDR_DUMMY_LOW:  regRdData <= dummyLow;
            `ADDR_CTRL4:      regRdData <= ctrl4;
            `ADDR_CTRL5:      regRdData <= ctrl5;
            default:          regRdData <= `RD_UNMAPPED;
         endcase
      end
   end

endmodule // strobe_regs

`default_nettype wire

// ### core/strobe_width_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "strobe_flash_defines.svh"

module strobe_width_timer
   import strobe_flash_pkg::*;
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   input  wire logic                   load,
   input  wire logic [`WIDTH_BITS-1:0] loadValue,
   input  wire logic                   byRows,
   input  wire logic                   rowStart,
   output logic                        running
);

   logic [`WIDTH_BITS-1:0] remaining;

   // ==========================================================
   // Down counter in rows or in clock cycles
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         remaining <= '0;
      end else if (load) begin
         remaining <= loadValue;
      end else if (running && (!byRows || rowStart)) begin
         remaining <= remaining - `WIDTH_BITS'(1);
      end
   end

   assign running = (remaining != '0);

endmodule // strobe_width_timer

`default_nettype wire

// ### core/strobe_flash_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "strobe_flash_defines.svh"

module strobe_flash_controller
   import strobe_flash_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        frameStart,
   input  wire logic        rowStart,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [15:0] regAddr,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  regRdData,
   output logic             strobe,
   output logic      [15:0] dummyLines
);

   // ==========================================================
   // Declarations
   logic [7:0]             ctrl0;
   logic [7:0]             dummyHigh;
   logic [7:0]             dummyLow;
   logic [7:0]             ctrl4;
   logic [7:0]             ctrl5;

   strobe_mode_t           mode;
   logic                   modeValid;
   logic                   request;
   logic                   requestPrev;
   logic                   requestRise;
   logic                   polarity;
   logic [1:0]             xenonWidth;
   logic [1:0]             latency;
   logic                   repeatEn;
   logic                   startSel;
   logic [5:0]             widthStep;
   logic [1:0]             widthGain;
   logic                   isXenon;
   logic                   isLed12;
   logic                   isLed3;
   logic                   isLed4;

   strobe_state_t          state;
   logic [2:0]             waitCount;
   logic [2:0]             frameDelay;
   logic [2:0]             frameBase;
   logic                   waitDone;
   logic                   enterPulse;
   logic                   pulseEnd;
   logic                   repeatPulse;
   logic [`WIDTH_BITS-1:0] widthLoad;
   logic [`WIDTH_BITS-1:0] xenonRows;
   logic [`WIDTH_BITS-1:0] led4Cycles;
   logic                   timerRunning;
   logic                   dummyHold;

   // ==========================================================
   // Register file
   strobe_regs regs (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .regWrite  (regWrite),
      .regRead   (regRead),
      .regAddr   (regAddr),
      .regWrData (regWrData),
      .ctrl0     (ctrl0),
      .dummyHigh (dummyHigh),
      .dummyLow  (dummyLow),
      .ctrl4     (ctrl4),
      .ctrl5     (ctrl5),
      .regRdData (regRdData)
   );

   // ==========================================================
   // Field decode
   assign request    = ctrl0[`REQ_BIT];
   assign polarity   = ctrl0[`POL_BIT];
   assign xenonWidth = ctrl0[`XWIDTH_MSB:`XWIDTH_LSB];
   assign latency    = ctrl4[`LATENCY_MSB:`LATENCY_LSB];
   assign repeatEn   = ctrl4[`REPEAT_BIT];
   assign startSel   = ctrl4[`START_SEL_BIT];
   assign widthStep  = ctrl5[`STEP_MSB:`STEP_LSB];
   assign widthGain  = ctrl5[`GAIN_MSB:`GAIN_LSB];

   always_comb begin
      mode      = MODE_XENON;
      modeValid = 1'b1;
      case (ctrl0[`MODE_MSB:`MODE_LSB])
         `MODE_XENON_CODE: mode = MODE_XENON;
         `MODE_LED1_CODE:  mode = MODE_LED1;
         `MODE_LED2_CODE:  mode = MODE_LED2;
         `MODE_LED3_CODE:  mode = MODE_LED3;
         `MODE_LED4_CODE:  mode = MODE_LED4;
         default:          modeValid = 1'b0;
      endcase
   end

   always_comb begin
      isXenon = 1'b0;
      isLed12 = 1'b0;
      isLed3  = 1'b0;
      isLed4  = 1'b0;
      if (modeValid) begin
         case (mode)
            MODE_XENON: isXenon = 1'b1;
            MODE_LED1:  isLed12 = 1'b1;
            MODE_LED2:  isLed12 = 1'b1;
            MODE_LED3:  isLed3  = 1'b1;
            MODE_LED4:  isLed4  = 1'b1;
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // Request edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         requestPrev <= 1'b0;
      end else begin
         requestPrev <= request;
      end
   end

   assign requestRise = request && !requestPrev;

   // ==========================================================
   // Frame delay before activation
   always_comb begin
      frameBase = `OTHER_FRAME_BASE;
      case (mode)
         MODE_XENON: begin
            frameBase = `XENON_FRAME_BASE;
         end
         MODE_LED1, MODE_LED2: begin
            frameBase = `LED12_FRAME_BASE;
         end
         default: begin
            frameBase = `OTHER_FRAME_BASE;
         end
      endcase
   end

   assign frameDelay = frameBase + {1'b0, latency};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         waitCount <= `WAIT_LAST;
      end else if (state == ST_IDLE) begin
         waitCount <= frameDelay;
      end else if ((state == ST_WAIT) && frameStart && !waitDone) begin
         waitCount <= waitCount - `WAIT_LAST;
      end
   end

   assign waitDone = (waitCount == `WAIT_LAST);

   // ==========================================================
   // Pulse width
   assign xenonRows  = `WIDTH_BITS'(xenonWidth) + `WIDTH_BITS'(1);
   assign led4Cycles = (`WIDTH_BITS'(widthStep) + `WIDTH_BITS'(1))
                       << (`WIDTH_UNIT_SHIFT + {3'h0, widthGain});
   // Timed pulse holds one cycle past the load, so the load is one short
   always_comb begin
      if (isXenon) begin
         widthLoad = xenonRows;
      end else begin
         widthLoad = led4Cycles - `WIDTH_BITS'(1);
      end
   end

   always_comb begin
      enterPulse = 1'b0;
      case (state)
         ST_WAIT: begin
            enterPulse = frameStart && waitDone && !startSel;
         end
         ST_ALIGN: begin
            enterPulse = rowStart;
         end
         ST_GAP: begin
            enterPulse = request && frameStart;
         end
         default: begin
            enterPulse = 1'b0;
         end
      endcase
   end

   strobe_width_timer widthTimer (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .load      (enterPulse),
      .loadValue (widthLoad),
      .byRows    (isXenon),
      .rowStart  (rowStart),
      .running   (timerRunning)
   );

   // ==========================================================
   // End of pulse and repetition
   always_comb begin
      pulseEnd    = 1'b1;
      repeatPulse = 1'b0;
      if (isXenon || isLed4) begin
         pulseEnd    = !timerRunning;
         repeatPulse = repeatEn && request;
      end else if (isLed12) begin
         pulseEnd    = frameStart;
         repeatPulse = request;
      end else if (isLed3) begin
         pulseEnd    = !request;
         repeatPulse = 1'b0;
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (requestRise && modeValid) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (frameStart && waitDone) begin
                  state <= startSel ? ST_ALIGN : ST_PULSE;
               end
            end
            ST_ALIGN: begin
               if (rowStart) begin
                  state <= ST_PULSE;
               end
            end
            ST_PULSE: begin
               if (pulseEnd) begin
                  state <= repeatPulse ? ST_GAP : ST_IDLE;
               end
            end
            ST_GAP: begin
               if (!request) begin
                  state <= ST_IDLE;
               end else if (frameStart) begin
                  state <= ST_PULSE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Strobe pin
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         strobe <= 1'b0;
      end else begin
         strobe <= (state == ST_PULSE) ^ polarity;
      end
   end

   // ==========================================================
   // Dummy lines to the frame timing
   assign dummyHold = isLed12 && request && (state != ST_IDLE);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         dummyLines <= '0;
      end else if (dummyHold) begin
         dummyLines <= {dummyHigh, dummyLow};
      end else begin
         dummyLines <= '0;
      end
   end

endmodule // strobe_flash_controller

`default_nettype wire

// ### verif/flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Flash module counting trigger edges
module flash_model (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       strobe,
   input  wire logic       activeLow,
   output logic      [7:0] fires
);
   logic last;
   always_ff @(posedge ref_clk) begin
      last <= strobe;
      if (rst) fires <= 8'h00;
      else if (strobe != last && strobe != activeLow) fires <= fires + 8'h01;
   end
endmodule // flash_model
`default_nettype wire

// ### verif/strobe_flash_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Port checks
module strobe_flash_asserts
   import strobe_flash_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        frameStart,
   input wire logic        rowStart,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [15:0] regAddr,
   input wire logic [7:0]  regWrData,
   input wire logic [7:0]  regRdData,
   input wire logic        strobe,
   input wire logic [15:0] dummyLines
);
   logic [7:0]  sh0;
   logic [7:0]  sh5;
   logic [15:0] shD;
   logic [16:0] run;
   logic        act;
   logic        w0;
   assign w0  = regWrite && regAddr == 16'h3B00;
   assign act = strobe ^ sh0[6];
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sh0 <= 8'h00;
         sh5 <= 8'h00;
         shD <= 16'h0000;
      end else if (regWrite) begin
         if (w0) sh0 <= regWrData & 8'hF7;
         if (regAddr == 16'h3B05) sh5 <= regWrData;
         if (regAddr == 16'h3B02) shD[15:8] <= regWrData;
         if (regAddr == 16'h3B03) shD[7:0] <= regWrData;
      end
   end
   always_ff @(posedge ref_clk) begin
      run <= (rst || !act) ? 17'h00000 : run + 17'h00001;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence quiet_s;
      !w0 && !$past(w0) && !$past(w0, 2);
   endsequence
   sequence rd0_s;
      regRead && regAddr == 16'h3B00;
   endsequence
   a_reset_idle: assert property (disable iff (1'b0) rst |=>
      !strobe && dummyLines == 16'h0000 && regRdData == 8'h00) else $error("busy after reset");
   a_ctrl0_read: assert property (rd0_s |=> regRdData == $past(sh0))
      else $error("control read mismatch");
   a_read_holds: assert property (!regRead |=> $stable(regRdData))
      else $error("read data moved");
   a_unmapped_read: assert property (regRead && !(regAddr inside {16'h3B00, 16'h3B02,
      16'h3B03, 16'h3B04, 16'h3B05}) |=> regRdData == 8'h00) else $error("unmapped read");
   a_start_edge: assert property ($rose(act) ##0 quiet_s |->
      $past(frameStart, 2) || $past(rowStart, 2)) else $error("strobe start off timing");
   a_dummy_value: assert property (dummyLines != 16'h0000 |->
      $past(sh0[7]) && dummyLines == $past(shD)) else $error("dummy lines wrong");
   a_led3_hold: assert property (act && sh0[2:0] == 3'h3 && sh0[7] ##0 quiet_s |=> act)
      else $error("held strobe dropped");
   a_led4_width: assert property ($fell(act) && sh0[2:0] == 3'h4 ##0 quiet_s |->
      run == (17'(sh5[7:2]) + 17'h00001) << (7 + sh5[1:0])) else $error("timed width wrong");
endmodule // strobe_flash_asserts
bind strobe_flash_controller strobe_flash_asserts i_strobe_flash_asserts (
   .ref_clk, .rst, .frameStart, .rowStart, .regWrite, .regRead,
   .regAddr, .regWrData, .regRdData, .strobe, .dummyLines);
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import strobe_flash_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        frameStart = 1'b0;
   logic        rowStart = 1'b0;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0]  regWrData = 8'h00;
   logic [7:0]  regRdData;
   logic        strobe;
   logic [15:0] dummyLines;
   logic [7:0]  fires;
   logic        pol = 1'b0;
   logic [8:0]  tick = 9'h000;
   int          num_errors = 0;
   int          samples_checked = 0;
   initial forever #2.5 ref_clk = ~ref_clk;
   // ==========================
   // Frame of 40 rows, 8 cycles a row
   always @(posedge ref_clk) begin
      tick <= (tick == 9'h13F) ? 9'h000 : tick + 9'h001;
      frameStart <= tick == 9'h13F;
      rowStart <= tick[2:0] == 3'h3;
   end
   strobe_flash_controller i_strobe_flash_controller (.ref_clk, .rst, .frameStart,
      .rowStart, .regWrite, .regRead, .regAddr, .regWrData, .regRdData, .strobe, .dummyLines);
   flash_model i_flash_model (.ref_clk, .rst, .strobe, .activeLow(pol), .fires);
   // ==========================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic limit(input int k, input int lim);
      if (k >= lim) begin
         num_errors++;
         summarize();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      @(posedge ref_clk);
      d = regRdData;
   endtask
   task automatic rises(input int cyc, output int r);
      logic was;
      r = 0;
      was = strobe ^ pol;
      repeat (cyc) begin
         @(posedge ref_clk);
         r += int'((strobe ^ pol) && !was);
         was = strobe ^ pol;
      end
   endtask
   task automatic arm(input logic [7:0] c0, output int f, output int n);
      int k;
      pol <= c0[6];
      wr(16'h3B00, c0 & 8'h7F);
      for (k = 0; k < 400 && frameStart !== 1'b1; k++) @(posedge ref_clk);
      limit(k, 400);
      wr(16'h3B00, c0);
      f = 0;
      n = 0;
      for (k = 0; k < 3000 && (strobe ^ pol) !== 1'b1; k++) begin
         @(posedge ref_clk);
         n = frameStart ? 0 : n + 1;
         f += int'(frameStart);
      end
      limit(k, 3000);
   endtask
   // ==========================
   // Scenarios
   task automatic regs();
      logic [15:0] a [6] = '{16'h3B00, 16'h3B02, 16'h3B03, 16'h3B04, 16'h3B05, 16'h3B01};
      logic [7:0]  m [6] = '{8'hF7, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h00};
      logic [7:0]  d;
      for (int i = 0; i < 6; i++) begin
         rd(a[i], d);
         chk(d, 8'h00);
         wr(a[i], 8'hFF);
         rd(a[i], d);
         chk(d, m[i]);
         wr(a[i], 8'h00);
      end
   endtask
   task automatic pulse(input logic [7:0] c0, c4, c5, input int fr, ld, len, input logic rows);
      int f;
      int n;
      int k;
      logic [7:0] f0;
      wr(16'h3B04, c4);
      wr(16'h3B05, c5);
      f0 = fires;
      arm(c0, f, n);
      chk(f, fr);
      chk(n, ld);
      n = 0;
      for (k = 0; k < 9000 && (strobe ^ pol) === 1'b1; k++) begin
         n += rows ? int'(rowStart) : 1;
         @(posedge ref_clk);
      end
      limit(k, 9000);
      chk(n, len);
      wr(16'h3B00, c0 & 8'h7F);
      chk(fires - f0, 8'h01);
   endtask
   task automatic led2();
      int f;
      int n;
      int r;
      wr(16'h3B02, 8'h01);
      wr(16'h3B03, 8'h23);
      wr(16'h3B04, 8'h00);
      arm(8'h82, f, n);
      chk(f, 2);
      chk(dummyLines, 16'h0123);
      rises(1400, r);
      chk(r, 2);
      wr(16'h3B00, 8'h02);
      rises(400, r);
      chk(r, 0);
      chk(dummyLines, 16'h0000);
      chk(strobe ^ pol, 1'b0);
      rises(700, r);
      chk(r, 0);
   endtask
   task automatic led3();
      int f;
      int n;
      int r;
      arm(8'h83, f, n);
      chk(f, 1);
      rises(700, r);
      chk(r, 0);
      chk(strobe ^ pol, 1'b1);
      wr(16'h3B00, 8'h03);
      rises(8, r);
      chk(strobe ^ pol, 1'b0);
   endtask
   task automatic others();
      int f;
      int n;
      int r;
      wr(16'h3B04, 8'h04);
      arm(8'h84, f, n);
      rises(1000, r);
      chk(r, 3);
      wr(16'h3B00, 8'h04);
      rises(700, r);
      chk(r, 0);
      wr(16'h3B00, 8'h85);
      rises(1000, r);
      chk(r, 0);
      chk(strobe, 1'b0);
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      regs();
      pulse(8'hB0, 8'h02, 8'h00, 5, 2, 4, 1'b1);
      pulse(8'hC0, 8'h00, 8'h00, 3, 2, 1, 1'b1);
      pulse(8'h84, 8'h01, 8'h04, 2, 2, 256, 1'b0);
      pulse(8'h84, 8'h0B, 8'h02, 4, 6, 512, 1'b0);
      pulse(8'h84, 8'h00, 8'hF8, 1, 2, 8064, 1'b0);
      pulse(8'h81, 8'h00, 8'h00, 2, 2, 320, 1'b0);
      led2();
      led3();
      others();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
